// ---- verilog/rsc_pkg.sv ----
package rsc_pkg;

  // Register byte addresses
  localparam logic [3:0] RSC_ADDR_DEVICE_IDENTIFIER = 4'h0;
  localparam logic [3:0] RSC_ADDR_SILICON_REVISION  = 4'h4;
  localparam logic [3:0] RSC_ADDR_BROWNOUT_CONTROL  = 4'h8;
  localparam logic [3:0] RSC_ADDR_RESET_STATUS      = 4'hc;

  // Brown-out control field positions and reset values
  localparam int         RSC_BIT_SW_ENABLE  = 7;
  localparam int         RSC_BIT_FAST_START = 6;
  localparam int         RSC_BIT_READY      = 0;
  localparam logic       RSC_RST_SW_ENABLE  = 1'b1;
  localparam logic       RSC_RST_FAST_START = 1'b0;

  // Identification words: arbitrary neutral values
  localparam logic [13:0] RSC_DEVICE_ID_DEFAULT   = 14'h0a5a;
  localparam logic [13:0] RSC_REVISION_ID_DEFAULT = 14'h0001;

  // Timing
  localparam int RSC_CLK_HZ              = 40_000_000;
  localparam int RSC_POWER_UP_TIMER_MS             = 64;
  localparam int RSC_POWER_UP_TIMER_CYCLES         = RSC_CLK_HZ / 1000 * RSC_POWER_UP_TIMER_MS;
  localparam int RSC_BOR_FILTER_NS       = 1000;
  localparam int RSC_BOR_FILTER_CYCLES   = (RSC_BOR_FILTER_NS * 40 + 999) / 1000;
  localparam int RSC_PIN_FILTER_NS       = 200;
  localparam int RSC_PIN_FILTER_CYCLES   = (RSC_PIN_FILTER_NS * 40 + 999) / 1000;
  localparam int RSC_EXEC_DELAY_CYCLES   = 10;

  typedef enum logic [1:0] {
    RSC_BOR_OFF  = 2'b00,
    RSC_BOR_SW   = 2'b01,
    RSC_BOR_NSLP = 2'b10,
    RSC_BOR_ON   = 2'b11
  } rsc_bor_mode_e;

  typedef enum logic [1:0] {
    RSC_ST_HOLD,
    RSC_ST_POWER_UP_TIMER,
    RSC_ST_EXEC_WAIT,
    RSC_ST_RUN
  } rsc_seq_e;

  // Configuration word fields
  typedef struct packed {
    rsc_bor_mode_e brownout_mode_select;
    logic          brownout_level_select;
    logic          power_up_timer_enable_n;
    logic          low_power_brownout_n;
    logic          ext_reset_pin_enable;
    logic          low_voltage_program_enable;
  } rsc_cfg_s;

  // Other reset sources from neighbouring logic
  typedef struct packed {
    logic watchdog;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic program_exit;
  } rsc_src_s;

endpackage

// ---- verilog/rsc_reset_source_controller.sv ----
// Notes on behaviour
// - Nine reset sources recognised and combined.
// - Hold reset until supply reaches minimum.
// - Enabled power-up timer adds 64 ms.
// - Timer enabled by low bit, starts after release.
// - Four brown-out modes from 2-bit select.
// - Brown-out trips only after filtered dip.
// - Level select picks low or high trip.
// - Mode 11 waits ready; active in sleep.
// - Mode 10 waits ready; off in sleep.
// - Mode 01 no wait; follows software enable.
// - Software enable bit 7, reset one.
// - Fast start bit 6 forces band gap in modes 10 and 01.
// - Ready status bit 0 shows detector active.
// - Low-power brown-out ORed into brown-out flag.
// - Low-power detector enabled by config bit.
// - Pin disabled only when both bits zero.
// - Low pin holds device in reset.
// - Short pin pulses filtered out.
// - Device never drives reset pin.
// - Disabled pin is input, software pull-up.
// - Read-only 14-bit identification words.
// - Execution waits timers and pin release.
// - Late pin release starts after 10 cycles.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller #(
  parameter int          POWER_UP_TIMER_CYCLES  = rsc_pkg::RSC_POWER_UP_TIMER_CYCLES,
  parameter logic [13:0] DEVICE_ID    = rsc_pkg::RSC_DEVICE_ID_DEFAULT,
  parameter logic [13:0] REVISION_ID  = rsc_pkg::RSC_REVISION_ID_DEFAULT
) (
  input  wire logic             mclk,                  // Device clock
  input  wire logic             reset,                 // Async power-on reset, active high
  input  wire rsc_pkg::rsc_cfg_s cfg,                  // Configuration word fields
  input  wire logic             supply_ok,             // Supply at minimum level (pin domain)
  input  wire logic             bor_below_low,         // Supply under low trip (pin domain)
  input  wire logic             bor_below_high,        // Supply under high trip (pin domain)
  input  wire logic             bor_analog_ready,      // Detector settled (pin domain)
  input  wire logic             low_power_brownout_trip, // Low-power detector trip (pin domain)
  input  wire logic             ext_reset_pin_i,       // External reset pin level
  output logic                  ext_reset_pin_o,       // Pin drive value, always low
  output logic                  ext_reset_pin_oe,      // Pin drive enable, never set
  output logic                  ext_reset_pullup_en,   // Weak pull-up enable
  input  wire logic             sw_pullup_req,         // Software pull-up when pin is plain input
  output logic                  ext_reset_gpio_in,     // Pin as general input
  input  wire logic             sleeping,              // Core in sleep
  input  wire rsc_pkg::rsc_src_s other_src,            // Other reset sources
  input  wire logic             osc_timer_done,        // Oscillator start-up timer expired
  output logic                  bor_detector_en,       // Enable to analog detector
  output logic                  band_gap_force_on,     // Keep band gap running
  output logic                  wake_hold,             // Delay wake-up for detector
  output logic                  brownout_flag,         // Combined brown-out event pulse
  output logic                  core_reset,            // Core reset, active high
  input  wire logic [31:0]      s_axi_awaddr,          // AXI write address
  input  wire logic             s_axi_awvalid,         // AXI write address valid
  output logic                  s_axi_awready,         // AXI write address ready
  input  wire logic [31:0]      s_axi_wdata,           // AXI write data
  input  wire logic [3:0]       s_axi_wstrb,           // AXI write strobes
  input  wire logic             s_axi_wvalid,          // AXI write data valid
  output logic                  s_axi_wready,          // AXI write data ready
  output logic [1:0]            s_axi_bresp,           // AXI write response
  output logic                  s_axi_bvalid,          // AXI write response valid
  input  wire logic             s_axi_bready,          // AXI write response ready
  input  wire logic [31:0]      s_axi_araddr,          // AXI read address
  input  wire logic             s_axi_arvalid,         // AXI read address valid
  output logic                  s_axi_arready,         // AXI read address ready
  output logic [31:0]           s_axi_rdata,           // AXI read data
  output logic [1:0]            s_axi_rresp,           // AXI read response
  output logic                  s_axi_rvalid,          // AXI read data valid
  input  wire logic             s_axi_rready           // AXI read data ready
);
  import rsc_pkg::*;

  localparam int NSYNC = 6;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [15:0]      bor_cnt;
    logic             bor_trip;
    logic [15:0]      pin_cnt;
    logic             pin_low;
    logic [31:0]      power_up_timer_cnt;
    logic [3:0]       exec_cnt;
    rsc_seq_e         seq;
    logic             sw_enable;
    logic             fast_start;
    logic             brown_prev;
    logic             brownout_flag;
    logic             core_reset;
    logic             aw_hold;
    logic [3:0]       aw_addr;
    logic             w_hold;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } rsc_state_s;

  rsc_state_s s_q;
  rsc_state_s s_d;

  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == RSC_ADDR_DEVICE_IDENTIFIER) || (a == RSC_ADDR_SILICON_REVISION) ||
                  (a == RSC_ADDR_BROWNOUT_CONTROL) || (a == RSC_ADDR_RESET_STATUS);
  endfunction

  logic       supply_ok_s;
  logic       below_low_s;
  logic       below_high_s;
  logic       ready_s;
  logic       lp_trip_s;
  logic       pin_s;
  logic       pin_enabled;
  logic       below_sel;
  logic       det_active;
  logic       start_hold;
  logic       brown_req;
  logic       other_req;
  logic       power_up_timer_en;
  logic [7:0] brownout_control_rd;

  always_comb
  begin
    supply_ok_s  = s_q.sync2[0];
    below_low_s  = s_q.sync2[1];
    below_high_s = s_q.sync2[2];
    ready_s      = s_q.sync2[3];
    lp_trip_s    = s_q.sync2[4];
    pin_s        = s_q.sync2[5];
    pin_enabled  = cfg.ext_reset_pin_enable | cfg.low_voltage_program_enable;
    below_sel    = cfg.brownout_level_select ? below_low_s : below_high_s;
    power_up_timer_en      = ~cfg.power_up_timer_enable_n;
    other_req    = |other_src;
    case (cfg.brownout_mode_select)
      RSC_BOR_ON:   bor_detector_en = 1'b1;
      RSC_BOR_NSLP: bor_detector_en = ~sleeping;
      RSC_BOR_SW:   bor_detector_en = s_q.sw_enable;
      default:      bor_detector_en = 1'b0;
    endcase
    det_active   = bor_detector_en & ready_s;
    // Start-up hold only in the always-on and awake-only modes
    start_hold   = cfg.brownout_mode_select[1] & (~ready_s | below_sel);
    band_gap_force_on = (cfg.brownout_mode_select == RSC_BOR_NSLP ||
                         cfg.brownout_mode_select == RSC_BOR_SW) & s_q.fast_start;
    wake_hold    = (cfg.brownout_mode_select == RSC_BOR_NSLP) & ~ready_s;
    brown_req    = s_q.bor_trip | (lp_trip_s & ~cfg.low_power_brownout_n);
    brownout_control_rd    = 8'h00;
    brownout_control_rd[RSC_BIT_SW_ENABLE]  = s_q.sw_enable;
    brownout_control_rd[RSC_BIT_FAST_START] = s_q.fast_start;
    brownout_control_rd[RSC_BIT_READY]      = det_active;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = {ext_reset_pin_i, low_power_brownout_trip, bor_analog_ready,
                 bor_below_high, bor_below_low, supply_ok};
    s_d.sync2 = s_q.sync1;

    // Brown-out dip filter
    if (det_active && below_sel)
    begin
      if (s_q.bor_cnt < 16'(RSC_BOR_FILTER_CYCLES))
        s_d.bor_cnt = s_q.bor_cnt + 16'h0001;
      else
        s_d.bor_trip = 1'b1;
    end
    else
    begin
      s_d.bor_cnt  = 16'h0000;
      s_d.bor_trip = 1'b0;
    end

    // Pin noise filter: pin_low follows only a level stable past the window
    if ((~pin_s) != s_q.pin_low)
    begin
      if (s_q.pin_cnt < 16'(RSC_PIN_FILTER_CYCLES))
        s_d.pin_cnt = s_q.pin_cnt + 16'h0001;
      else
      begin
        s_d.pin_low = ~pin_s;
        s_d.pin_cnt = 16'h0000;
      end
    end
    else
      s_d.pin_cnt = 16'h0000;

    s_d.brown_prev    = brown_req;
    s_d.brownout_flag = brown_req & ~s_q.brown_prev;

    // Start-up sequence; pin hold runs independently of the timers
    case (s_q.seq)
      RSC_ST_HOLD:
      begin
        s_d.power_up_timer_cnt = 32'h0;
        if (supply_ok_s && !brown_req && !start_hold)
          s_d.seq = power_up_timer_en ? RSC_ST_POWER_UP_TIMER : RSC_ST_EXEC_WAIT;
      end
      RSC_ST_POWER_UP_TIMER:
      begin
        if (s_q.power_up_timer_cnt >= 32'(POWER_UP_TIMER_CYCLES - 1))
          s_d.seq = RSC_ST_EXEC_WAIT;
        else
          s_d.power_up_timer_cnt = s_q.power_up_timer_cnt + 32'h1;
      end
      RSC_ST_EXEC_WAIT:
      begin
        if (!osc_timer_done || (pin_enabled && s_q.pin_low))
          s_d.exec_cnt = 4'h0;
        else if (s_q.exec_cnt >= 4'(RSC_EXEC_DELAY_CYCLES - 1))
          s_d.seq = RSC_ST_RUN;
        else
          s_d.exec_cnt = s_q.exec_cnt + 4'h1;
      end
      RSC_ST_RUN:
      begin
        s_d.exec_cnt = 4'h0;
        if (pin_enabled && s_q.pin_low)
          s_d.seq = RSC_ST_EXEC_WAIT;
      end
      default: s_d.seq = RSC_ST_HOLD;
    endcase
    if (!supply_ok_s || brown_req || other_req)
      s_d.seq = RSC_ST_HOLD;
    s_d.core_reset = (s_d.seq != RSC_ST_RUN);

    // AXI4-Lite write
    if (s_axi_awvalid && !s_q.aw_hold)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && !s_q.w_hold)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_hold && s_q.w_hold && !s_q.bvalid)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = addr_mapped(s_q.aw_addr) ? 2'b00 : 2'b10;
      // Identification words ignore writes
      if (s_q.aw_addr == RSC_ADDR_BROWNOUT_CONTROL && s_q.w_strb[0])
      begin
        s_d.sw_enable  = s_q.w_data[RSC_BIT_SW_ENABLE];
        s_d.fast_start = s_q.w_data[RSC_BIT_FAST_START];
      end
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // AXI4-Lite read
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = addr_mapped(s_axi_araddr[3:0]) ? 2'b00 : 2'b10;
      case (s_axi_araddr[3:0])
        RSC_ADDR_DEVICE_IDENTIFIER: s_d.rdata = {18'h0, DEVICE_ID};
        RSC_ADDR_SILICON_REVISION:  s_d.rdata = {18'h0, REVISION_ID};
        RSC_ADDR_BROWNOUT_CONTROL:  s_d.rdata = {24'h0, brownout_control_rd};
        RSC_ADDR_RESET_STATUS:      s_d.rdata = {28'h0, pin_enabled, s_q.pin_low,
                                                 s_q.bor_trip, s_q.core_reset};
        default:                    s_d.rdata = 32'h0;
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_q            <= '0;
      s_q.sync1      <= 6'h20;
      s_q.sync2      <= 6'h20;
      s_q.seq        <= RSC_ST_HOLD;
      s_q.sw_enable  <= RSC_RST_SW_ENABLE;
      s_q.fast_start <= RSC_RST_FAST_START;
      s_q.core_reset <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  always_comb
  begin
    ext_reset_pin_o     = 1'b0;
    ext_reset_pin_oe    = 1'b0;
    ext_reset_pullup_en = pin_enabled | sw_pullup_req;
    ext_reset_gpio_in   = pin_s;
    brownout_flag       = s_q.brownout_flag;
    core_reset          = s_q.core_reset;
    s_axi_awready       = ~s_q.aw_hold;
    s_axi_wready        = ~s_q.w_hold;
    s_axi_bvalid        = s_q.bvalid;
    s_axi_bresp         = s_q.bresp;
    s_axi_arready       = ~s_q.rvalid;
    s_axi_rvalid        = s_q.rvalid;
    s_axi_rdata         = s_q.rdata;
    s_axi_rresp         = s_q.rresp;
  end

  property p_pin_never_driven;
    @(posedge mclk) disable iff (reset) !ext_reset_pin_oe;
  endproperty
  a_pin_never_driven: assert property (p_pin_never_driven) else $error("reset pin driven");

  property p_other_src_resets;
    @(posedge mclk) disable iff (reset) other_req |=> core_reset;
  endproperty
  a_other_src_resets: assert property (p_other_src_resets) else $error("source missed");

  property p_supply_low;
    @(posedge mclk) disable iff (reset) !supply_ok_s |=> core_reset;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("supply low not held");

  property p_pin_holds;
    @(posedge mclk) disable iff (reset) (pin_enabled && s_q.pin_low) |=> core_reset;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("pin low not held");

  property p_pin_disable;
    @(posedge mclk) disable iff (reset)
      pin_enabled == (cfg.ext_reset_pin_enable || cfg.low_voltage_program_enable);
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("pin enable wrong");

  property p_exec_delay;
    @(posedge mclk) disable iff (reset)
      $fell(core_reset) |-> $past(s_q.seq) == RSC_ST_EXEC_WAIT && $past(s_q.exec_cnt) == 4'h9;
  endproperty
  a_exec_delay: assert property (p_exec_delay) else $error("release not after 10 cycles");

  property p_bor_filter;
    @(posedge mclk) disable iff (reset) $rose(s_q.bor_trip) |-> $past(det_active && below_sel, 2);
  endproperty
  a_bor_filter: assert property (p_bor_filter) else $error("unfiltered trip");

  property p_flag_or;
    @(posedge mclk) disable iff (reset) $rose(brown_req) |=> brownout_flag;
  endproperty
  a_flag_or: assert property (p_flag_or) else $error("flag missed");

  property p_wake_hold;
    @(posedge mclk) disable iff (reset)
      wake_hold |-> cfg.brownout_mode_select == RSC_BOR_NSLP && !ready_s;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake hold wrong");

  // A filtered pin low must have been seen low nine cycles before it rose
  property p_pin_filter;
    @(posedge mclk) disable iff (reset) $rose(s_q.pin_low) |-> $past(!pin_s, 9);
  endproperty
  a_pin_filter: assert property (p_pin_filter) else $error("pin pulse not filtered");

  c_release: cover property (@(posedge mclk) disable iff (reset) $fell(core_reset));
  c_power_up_timer: cover property (@(posedge mclk) disable iff (reset) s_q.seq == RSC_ST_POWER_UP_TIMER);
  c_brown: cover property (@(posedge mclk) disable iff (reset) brownout_flag);
  c_pin_reset: cover property (@(posedge mclk) disable iff (reset) pin_enabled && s_q.pin_low);
endmodule
`default_nettype wire

// ---- testbench/rsc_far_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side_model (
  input  wire logic mclk,                    // Device clock
  input  wire logic supply_good,             // Supply above minimum level
  input  wire logic dip_high,                // Supply under the high trip only
  input  wire logic dip_low,                 // Supply under both trips
  input  wire logic lp_dip,                  // Low-power detector sees a low supply
  input  wire logic pin_pull_low,            // Outside party pulls the reset pin low
  input  wire logic det_en,                  // Detector enable from the device
  input  wire logic pin_o,                   // Device pin drive value
  input  wire logic pin_oe,                  // Device pin drive enable
  output logic      supply_ok,               // Supply monitor result
  output logic      bor_below_low,           // Under low trip
  output logic      bor_below_high,          // Under high trip
  output logic      bor_analog_ready,        // Detector settled
  output logic      low_power_brownout_trip, // Low-power detector trip
  output logic      pin                      // Resolved reset pin level
);
  logic [2:0] rdy_q = 3'h0;

  assign supply_ok = supply_good;
  assign bor_below_low = dip_low;
  assign bor_below_high = dip_low | dip_high;
  assign low_power_brownout_trip = lp_dip;
  // Weak pull-up wins when nobody drives the pin
  assign pin = pin_oe ? pin_o : !pin_pull_low;
  // Detector needs a few cycles to settle after it is enabled
  always_ff @(posedge mclk)
  begin
    rdy_q <= !det_en ? 3'h0 : (rdy_q == 3'h7) ? rdy_q : rdy_q + 3'h1;
  end
  assign bor_analog_ready = (rdy_q == 3'h7);
endmodule
`default_nettype wire

// ---- testbench/rsc_reset_source_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller_tb;
  import rsc_pkg::*;
  localparam int POWER_UP_TIMER = 50;
  logic        mclk = 1'b0;
  logic        reset, supply_good, dip_high, dip_low, lp_dip, pin_pull_low, sleeping, sw_pullup_req;
  logic        supply_ok, below_low, below_high, an_ready, lp_trip, pin, pin_o, pin_oe, pullup_en, gpio_in;
  logic        det_en, bg_on, wake_hold, bo_flag, core_reset;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  rsc_cfg_s    cfg;
  rsc_src_s    other_src;
  logic        osc_done;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #12.5 mclk = ~mclk;

  rsc_reset_source_controller #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) dut_u (
    .mclk(mclk), .reset(reset), .cfg(cfg), .supply_ok(supply_ok), .bor_below_low(below_low),
    .bor_below_high(below_high), .bor_analog_ready(an_ready), .low_power_brownout_trip(lp_trip),
    .ext_reset_pin_i(pin), .ext_reset_pin_o(pin_o), .ext_reset_pin_oe(pin_oe), .ext_reset_pullup_en(pullup_en),
    .sw_pullup_req(sw_pullup_req), .ext_reset_gpio_in(gpio_in), .sleeping(sleeping), .other_src(other_src),
    .osc_timer_done(osc_done), .bor_detector_en(det_en), .band_gap_force_on(bg_on), .wake_hold(wake_hold),
    .brownout_flag(bo_flag), .core_reset(core_reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  rsc_far_side_model far_u (
    .mclk(mclk), .supply_good(supply_good), .dip_high(dip_high), .dip_low(dip_low), .lp_dip(lp_dip),
    .pin_pull_low(pin_pull_low), .det_en(det_en), .pin_o(pin_o), .pin_oe(pin_oe), .supply_ok(supply_ok),
    .bor_below_low(below_low), .bor_below_high(below_high), .bor_analog_ready(an_ready),
    .low_power_brownout_trip(lp_trip), .pin(pin));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= {28'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 2'b00, bresp);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [1:0] exp_resp);
    @(posedge mclk);
    araddr <= {28'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    chk("rresp", exp_resp, rresp);
  endtask

  task automatic wait_release(output int n);
    n = 0;
    while (core_reset !== 1'b0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk("core reset released", 0, core_reset);
  endtask

  task automatic t_startup();
    int n;
    repeat (20) @(posedge mclk);
    chk("reset held without supply", 1, core_reset);
    supply_good <= 1'b1;
    wait_release(n);
    chk("release after timer", 1, n >= POWER_UP_TIMER + 10 && n <= POWER_UP_TIMER + 30);
    $display("test startup done");
  endtask

  task automatic t_regs();
    axi_rd(RSC_ADDR_DEVICE_IDENTIFIER, 2'b00);
    chk("device id", {18'h0, RSC_DEVICE_ID_DEFAULT}, rd);
    axi_wr(RSC_ADDR_DEVICE_IDENTIFIER, 32'h0000_1234);
    axi_rd(RSC_ADDR_DEVICE_IDENTIFIER, 2'b00);
    chk("device id after write", {18'h0, RSC_DEVICE_ID_DEFAULT}, rd);
    axi_rd(RSC_ADDR_SILICON_REVISION, 2'b00);
    chk("revision id", {18'h0, RSC_REVISION_ID_DEFAULT}, rd);
    axi_rd(RSC_ADDR_BROWNOUT_CONTROL, 2'b00);
    chk("control reset", 32'h0000_0081, rd);
    axi_rd(4'h6, 2'b10);
    $display("test registers done");
  endtask

  // Another source, then a mid-run reset with the oscillator timer late
  task automatic t_restart();
    int n;
    @(posedge mclk);
    other_src.watchdog <= 1'b1;
    @(posedge mclk);
    other_src <= '0;
    repeat (2) @(posedge mclk);
    chk("watchdog source resets", 1, core_reset);
    reset <= 1'b1;
    osc_done <= 1'b0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (POWER_UP_TIMER + 20) @(posedge mclk);
    chk("held for oscillator timer", 1, core_reset);
    osc_done <= 1'b1;
    wait_release(n);
    chk("osc release", 1, n >= RSC_EXEC_DELAY_CYCLES && n <= RSC_EXEC_DELAY_CYCLES + 4);
    axi_rd(RSC_ADDR_BROWNOUT_CONTROL, 2'b00);
    chk("control after reset", 32'h0000_0081, rd);
    $display("test restart done");
  endtask

  task automatic t_modes();
    logic de;
    for (int c = 0; c < 4; c++)
    begin
      axi_wr(RSC_ADDR_BROWNOUT_CONTROL, {24'h0, c[1], c[0], 6'h0});
      for (int m = 0; m < 8; m++)
      begin
        @(posedge mclk);
        cfg.brownout_mode_select <= rsc_bor_mode_e'(m[2:1]);
        sleeping <= m[0];
        repeat (12) @(posedge mclk);
        de = (m[2:1] == 2'b11) || (m[2:1] == 2'b10 && !m[0]) || (m[2:1] == 2'b01 && c[1]);
        chk("detector enable", de, det_en);
        chk("band gap", c[0] && (m[2:1] == 2'b10 || m[2:1] == 2'b01), bg_on);
        if (m[2:1] == 2'b11) chk("wake hold", 0, wake_hold);
        if (m[2:1] == 2'b10) chk("wake hold in sleep", m[0], wake_hold);
        axi_rd(RSC_ADDR_BROWNOUT_CONTROL, 2'b00);
        chk("control bits", {24'h0, c[1], c[0], 5'h0, de}, rd);
      end
    end
    @(posedge mclk);
    sleeping <= 1'b0;
    cfg.brownout_mode_select <= RSC_BOR_ON;
    axi_wr(RSC_ADDR_BROWNOUT_CONTROL, 32'h0000_0080);
    $display("test modes done");
  endtask

  // Pulls the supply or the pin low for len cycles and judges the reaction
  task automatic stim(input int kind, input int len, input logic exp);
    logic fl, rs;
    int n;
    fl = 0;
    rs = 0;
    for (int i = 0; i < len + 6; i++)
    begin
      @(posedge mclk);
      dip_high <= (kind == 0) && i < len;
      lp_dip <= (kind == 1) && i < len;
      pin_pull_low <= (kind == 2) && i < len;
      fl |= bo_flag;
      rs |= core_reset;
    end
    wait_release(n);
    chk("reset seen", exp, rs);
    if (kind != 2) chk("brownout flag", exp, fl);
    if (kind == 2 && exp)
      chk("pin release delay", 1, n >= RSC_EXEC_DELAY_CYCLES && n <= RSC_EXEC_DELAY_CYCLES + 16);
    chk("pin never driven", 0, pin_oe);
  endtask

  task automatic t_faults();
    stim(0, 20, 0);
    stim(0, 60, 1);
    cfg.brownout_level_select <= 1'b1;
    stim(0, 60, 0);
    cfg.brownout_mode_select <= RSC_BOR_OFF;
    cfg.brownout_level_select <= 1'b0;
    stim(0, 60, 0);
    stim(1, 60, 0);
    cfg.low_power_brownout_n <= 1'b0;
    stim(1, 60, 1);
    stim(2, 4, 0);
    stim(2, 30, 1);
    cfg.ext_reset_pin_enable <= 1'b0;
    sw_pullup_req <= 1'b1;
    stim(2, 30, 0);
    repeat (4) @(posedge mclk);
    chk("pull-up by software", 1, pullup_en);
    pin_pull_low <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("pin as input", 0, gpio_in);
    sw_pullup_req <= 1'b0;
    pin_pull_low <= 1'b0;
    repeat (16) @(posedge mclk);
    chk("pull-up off by software", 0, pullup_en);
    cfg.low_voltage_program_enable <= 1'b1;
    stim(2, 30, 1);
    $display("test faults done");
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    reset = 1'b1;
    cfg = '{RSC_BOR_ON, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    {supply_good, dip_high, dip_low, lp_dip, pin_pull_low, sleeping, sw_pullup_req} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    osc_done = 1'b1;
    other_src = '0;
    {awaddr, wdata, araddr, wstrb} = {96'h0, 4'hf};
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_startup();
    t_regs();
    t_restart();
    t_modes();
    t_faults();
    print_verdict();
  end
endmodule
`default_nettype wire
